// *** rtl/isw_defs.svh ***
// Constants for the four-channel bus switch control logic.
// Assumes inclusion by bare name from the package and the design files.
`ifndef ISW_DEFS_SVH
`define ISW_DEFS_SVH

// Channel count and control register
`define ISW_CH_COUNT      4
`define ISW_CTRL_RESET    4'h0
`define ISW_CTRL_LSB      0
`define ISW_CTRL_MSB      3

// Slave address: fixed upper five bits, two strap bits below (arbitrary value)
`define ISW_ADDR_BASE     5'h1c

// Byte framing
`define ISW_BYTE_W        8
`define ISW_BIT_LAST      4'h8
`define ISW_READ_PAD      4'h0

// Write buffer
`define ISW_FIFO_DEPTH    32

// Clock figures: 20 MHz core, upstream clock 0 to 400 kHz
`define ISW_CLK_KHZ       20000
`define ISW_SCL_MAX_KHZ   400

`endif

// *** rtl/isw_pkg.sv ***
// Types shared by the switch control logic, its checker and the testbench.
// Assumes isw_defs.svh is on the include path.
`include "isw_defs.svh"

package isw_pkg;

   // Upstream clock/data pair travels as one struct
   typedef struct packed {
      logic scl;
      logic sda;
   } isw_line_type;

   // Slave protocol states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE    = 7'h01,
      ST_ADDR    = 7'h02,
      ST_ADDR_AK = 7'h04,
      ST_WRITE   = 7'h08,
      ST_WR_AK   = 7'h10,
      ST_READ    = 7'h20,
      ST_RD_AK   = 7'h40
   } isw_state_type;

   typedef logic [`ISW_BYTE_W-1:0] isw_byte_type;

endpackage

// *** rtl/isw_fifo.sv ***
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset; DEPTH a power of two.
`timescale 1ns/100ps
`default_nettype none

module isw_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             mclk,
   input  wire logic             rst_b,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   // ==========================================================
   // Handshake
   assign in_ready  = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_r[rd_ptr_r];

   // Storage, no reset needed on data
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // Pointers wrap naturally at a power-of-two depth
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// *** rtl/isw_switch.sv ***
// Control logic of a four-channel bus switch with interrupt combining.
// Assumes bus pins arrive synchronous to mclk and open-drain wiring outside.
`include "isw_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module isw_switch (
   input  wire logic                          mclk,
   input  wire logic                          rst_b,
   input  wire isw_pkg::isw_line_type         up_line_in,
   output isw_pkg::isw_line_type              up_line_out,
   output isw_pkg::isw_line_type              up_line_oe,
   input  wire logic [`ISW_CH_COUNT-1:0]      downstream_clock_in,
   output logic      [`ISW_CH_COUNT-1:0]      downstream_clock_out,
   output logic      [`ISW_CH_COUNT-1:0]      downstream_clock_oe,
   input  wire logic [`ISW_CH_COUNT-1:0]      downstream_data_in,
   output logic      [`ISW_CH_COUNT-1:0]      downstream_data_out,
   output logic      [`ISW_CH_COUNT-1:0]      downstream_data_oe,
   input  wire logic [`ISW_CH_COUNT-1:0]      channel_irq_n,
   output logic                               irq_n,
   input  wire logic                          addr_sel_lo,
   input  wire logic                          addr_sel_hi,
   output logic      [`ISW_CH_COUNT-1:0]      chan_enable
);

   import isw_pkg::*;

   // ==========================================================
   // Declarations
   isw_state_type             state_r;
   isw_line_type              prev_r;
   isw_line_type              up_oe_r;
   isw_byte_type              rx_sh_r;
   isw_byte_type              tx_sh_r;
   logic [3:0]                bit_cnt_r;
   logic                      slave_oe_r;
   logic                      rd_nak_r;
   logic [`ISW_CH_COUNT-1:0]  ctrl_r;
   logic [`ISW_CH_COUNT-1:0]  ds_clk_oe_r;
   logic [`ISW_CH_COUNT-1:0]  ds_dat_oe_r;
   logic                      irq_n_r;
   logic                      scl_rise;
   logic                      scl_fall;
   logic                      start_cond;
   logic                      stop_cond;
   logic                      addr_match;
   logic                      byte_done;
   logic                      wr_push;
   logic                      fifo_in_ready;
   logic                      fifo_out_valid;
   logic                      fifo_out_ready;
   isw_byte_type              fifo_out_data;
   isw_byte_type              rd_byte;
   logic                      ds_clk_low;
   logic                      ds_dat_low;

   // Either address strap moves the slave into one of four slots
   function automatic logic match_addr(input isw_byte_type b, input logic hi, input logic lo);
      match_addr = (b[7:1] == {`ISW_ADDR_BASE, hi, lo});
   endfunction

   // ==========================================================
   // Bus condition detection
   // Edges come from comparing against the last sample; a 20 MHz core sees
   // at least 25 samples per half period even at the fastest upstream clock,
   // and a stopped clock simply produces no edges.
   assign scl_rise   = up_line_in.scl & ~prev_r.scl;
   assign scl_fall   = ~up_line_in.scl & prev_r.scl;
   assign start_cond = up_line_in.scl & prev_r.scl & prev_r.sda & ~up_line_in.sda;
   assign stop_cond  = up_line_in.scl & prev_r.scl & ~prev_r.sda & up_line_in.sda;
   assign addr_match = match_addr(rx_sh_r, addr_sel_hi, addr_sel_lo);
   assign byte_done  = scl_fall & (bit_cnt_r == `ISW_BIT_LAST);
   assign wr_push    = (state_r == ST_WRITE) & byte_done & fifo_in_ready;

   // Previous line sample
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         prev_r <= '{scl: 1'b1, sda: 1'b1};
      end else begin
         prev_r <= up_line_in;
      end
   end

   // ==========================================================
   // Slave protocol state machine
   // Reset from the rst_b pin drops the machine back to idle.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
      end else if (start_cond) begin
         state_r <= ST_ADDR;
      end else if (stop_cond) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               state_r <= ST_IDLE;
            end
            ST_ADDR: begin
               if (byte_done) begin
                  state_r <= addr_match ? ST_ADDR_AK : ST_IDLE;
               end
            end
            ST_ADDR_AK: begin
               if (scl_fall) begin
                  state_r <= rx_sh_r[0] ? ST_READ : ST_WRITE;
               end
            end
            ST_WRITE: begin
               if (byte_done) begin
                  state_r <= ST_WR_AK;
               end
            end
            ST_WR_AK: begin
               if (scl_fall) begin
                  state_r <= ST_WRITE;
               end
            end
            ST_READ: begin
               if (byte_done) begin
                  state_r <= ST_RD_AK;
               end
            end
            ST_RD_AK: begin
               if (scl_fall) begin
                  state_r <= rd_nak_r ? ST_IDLE : ST_READ;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Bit counter: counts rising clock edges inside a byte
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bit_cnt_r <= '0;
      end else if (start_cond || scl_fall && (bit_cnt_r == `ISW_BIT_LAST)) begin
         bit_cnt_r <= '0;
      end else if (scl_rise && (state_r == ST_ADDR || state_r == ST_WRITE
                                || state_r == ST_READ)) begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
      end
   end

   // Receive shifter, most significant bit first
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_sh_r <= '0;
      end else if (scl_rise && (state_r == ST_ADDR || state_r == ST_WRITE)) begin
         rx_sh_r <= {rx_sh_r[6:0], up_line_in.sda};
      end
   end

   // Master acknowledge after each read byte; a high level ends the read
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rd_nak_r <= 1'b0;
      end else if (scl_rise && state_r == ST_RD_AK) begin
         rd_nak_r <= up_line_in.sda;
      end
   end

   // Read-back byte: pad above the channel bits.
   // Its top bit goes out as soon as the address is acknowledged, so the
   // first data bit is settled long before the host raises the clock.
   assign rd_byte = {`ISW_READ_PAD, ctrl_r};

   // Transmit shifter: read-back returns the enabled channels, zero above
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tx_sh_r <= '0;
      end else if (scl_fall && (state_r == ST_ADDR_AK && rx_sh_r[0]
                                || state_r == ST_RD_AK && !rd_nak_r)) begin
         tx_sh_r <= rd_byte;
      end else if (scl_fall && state_r == ST_READ) begin
         tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
   end

   // Slave data drive: acknowledge slots and read data bits.
   // Changes only on falling clock so data is stable while the clock is high.
   // A full write buffer shows as a missing acknowledge, so the host backs off.
   // Read bits pull low for a zero; the host keeps the line released meanwhile.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         slave_oe_r <= 1'b0;
      end else if (start_cond || stop_cond) begin
         slave_oe_r <= 1'b0;
      end else if (scl_fall) begin
         unique case (state_r)
            ST_ADDR:    slave_oe_r <= byte_done & addr_match;
            ST_WRITE:   slave_oe_r <= wr_push;
            ST_ADDR_AK: slave_oe_r <= rx_sh_r[0] & ~rd_byte[`ISW_BYTE_W-1];
            ST_READ:    slave_oe_r <= ~byte_done & ~tx_sh_r[6];
            ST_RD_AK:   slave_oe_r <= ~rd_nak_r & ~rd_byte[`ISW_BYTE_W-1];
            default:    slave_oe_r <= 1'b0;
         endcase
      end
   end

   // ==========================================================
   // Write buffer and control register
   // Written bytes queue here; they take effect whenever the machine is in ST_IDLE,
   // also after a non-matching address, so the set can change during a foreign transfer.
   isw_fifo #(
      .WIDTH (`ISW_BYTE_W),
      .DEPTH (`ISW_FIFO_DEPTH)
   ) u_wr_fifo (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .in_valid  (wr_push),
      .in_ready  (fifo_in_ready),
      .in_data   (rx_sh_r),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   assign fifo_out_ready = (state_r == ST_IDLE);

   // Control register; each bit enables one channel, any mix allowed
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= `ISW_CTRL_RESET;
      end else if (fifo_out_valid && fifo_out_ready) begin
         ctrl_r <= fifo_out_data[`ISW_CTRL_MSB:`ISW_CTRL_LSB];
      end
   end

   // ==========================================================
   // Channel pass-through
   // Open-drain joining in both directions. Each side copies a low from the
   // other only when that low is not its own echo, which keeps the pair from
   // locking itself low once both sides have been driven.
   genvar ch;
   generate
      for (ch = 0; ch < `ISW_CH_COUNT; ch++) begin : g_chan
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               ds_clk_oe_r[ch] <= 1'b0;
               ds_dat_oe_r[ch] <= 1'b0;
            end else begin
               ds_clk_oe_r[ch] <= ctrl_r[ch] & ~up_line_in.scl & ~up_oe_r.scl;
               ds_dat_oe_r[ch] <= ctrl_r[ch] & ~up_line_in.sda & ~up_oe_r.sda;
            end
         end
      end
   endgenerate

   // A low on any enabled channel not caused by us reaches upstream
   assign ds_clk_low = |(ctrl_r & ~downstream_clock_in & ~ds_clk_oe_r);
   assign ds_dat_low = |(ctrl_r & ~downstream_data_in & ~ds_dat_oe_r);

   // Upstream drive: protocol drive or relayed downstream low
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         up_oe_r <= '0;
      end else begin
         up_oe_r.scl <= ds_clk_low;
         up_oe_r.sda <= ds_dat_low | slave_oe_r;
      end
   end

   // ==========================================================
   // Interrupt combining
   // Registered so the output is glitch-free; costs one cycle of latency.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_n_r <= 1'b1;
      end else begin
         irq_n_r <= &channel_irq_n;
      end
   end

   // ==========================================================
   // Outputs; open-drain pins only ever drive low
   assign up_line_out          = '0;
   assign up_line_oe           = up_oe_r;
   assign downstream_clock_out = '0;
   assign downstream_data_out  = '0;
   assign downstream_clock_oe  = ds_clk_oe_r;
   assign downstream_data_oe   = ds_dat_oe_r;
   assign irq_n                = irq_n_r;
   assign chan_enable          = ctrl_r;

endmodule

`default_nettype wire

// *** sim/isw_monitor.sv ***
// Checker for the switch top-level ports.
// Assumes isw_pkg is compiled first; bound into every isw_switch.
`timescale 1ns/100ps
`default_nettype none

module isw_monitor (
   input wire logic                  mclk,
   input wire logic                  rst_b,
   input wire isw_pkg::isw_line_type up_line_in,
   input wire isw_pkg::isw_line_type up_line_oe,
   input wire logic [3:0]            downstream_clock_oe,
   input wire logic [3:0]            downstream_data_oe,
   input wire logic [3:0]            channel_irq_n,
   input wire logic                  irq_n,
   input wire logic [3:0]            chan_enable
);
   import isw_pkg::*;
   // ==========
   // Bus events and relations
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_start;
      up_line_in.scl && $past(up_line_in.scl) && $fell(up_line_in.sda);
   endsequence
   // Four samples give the relay its 1-2 cycle latency
   sequence s_scl_low;
      (!up_line_in.scl && !up_line_oe.scl) [*4];
   endsequence
   sequence s_sda_low;
      (up_line_in.scl && !up_line_in.sda && !up_line_oe.sda) [*4];
   endsequence
   property p_irq_and;
      $past(rst_b) |-> irq_n == &$past(channel_irq_n);
   endproperty
   a_irq_and: assert property (p_irq_and)
      else $error("irq_n is not the AND of the inputs");
   property p_reset_clear;
      $rose(rst_b) |-> chan_enable == 4'h0 && irq_n && up_line_oe == 2'h0
         && (downstream_clock_oe | downstream_data_oe) == 4'h0;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("state not cleared by reset");
   property p_gate;
      ((downstream_clock_oe | downstream_data_oe) & ~(chan_enable | $past(chan_enable))) == 4'h0;
   endproperty
   a_gate: assert property (p_gate)
      else $error("disabled channel driven");
   property p_ds_clk;
      s_scl_low ##0 $stable(chan_enable) |-> downstream_clock_oe == chan_enable;
   endproperty
   a_ds_clk: assert property (p_ds_clk)
      else $error("clock low not passed to enabled channels");
   property p_ds_dat;
      s_sda_low ##0 $stable(chan_enable) |-> downstream_data_oe == chan_enable;
   endproperty
   a_ds_dat: assert property (p_ds_dat)
      else $error("data low not passed to enabled channels");
   property p_sda_change;
      $changed(up_line_oe.sda) |-> !up_line_in.scl && !$past(up_line_in.scl);
   endproperty
   a_sda_change: assert property (p_sda_change)
      else $error("upstream data drive changed outside clock low");
   property p_start_quiet;
      s_start |=> !up_line_oe.sda [*8];
   endproperty
   a_start_quiet: assert property (p_start_quiet)
      else $error("data driven right after start");
   property p_enable_idle;
      $changed(chan_enable) |-> up_line_in.scl && up_line_in.sda;
   endproperty
   a_enable_idle: assert property (p_enable_idle)
      else $error("selection changed while bus busy");
endmodule

bind isw_switch isw_monitor isw_monitor_inst (.mclk, .rst_b, .up_line_in, .up_line_oe,
   .downstream_clock_oe, .downstream_data_oe, .channel_irq_n, .irq_n, .chan_enable);

`default_nettype wire

// *** sim/isw_host.sv ***
// Host controller model on the upstream clock/data pair.
// Assumes open-drain wiring: a 1 on a drive output releases the line.
`timescale 1ns/100ps
`default_nettype none

module isw_host (
   input wire logic mclk,
   input wire logic sda_in,
   output var logic scl_drv,
   output var logic sda_drv
);
   int half = 25;
   // ==========
   // Bus phases, each held for half mclk cycles
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic step(input logic s, input logic d);
      scl_drv <= s;
      sda_drv <= d;
      repeat (half) @(posedge mclk);
   endtask
   task automatic start_cond;
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask
   task automatic stop_cond;
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   // Eight bits MSB first, then the acknowledge bit
   task automatic xfer_byte(input logic [7:0] d, input logic ack_in,
                            output logic [7:0] q, output logic ack);
      logic [8:0] v;
      logic [8:0] r;
      v = {d, ack_in};
      for (int i = 8; i >= 0; i--) begin
         step(1'b0, v[i]);
         step(1'b1, v[i]);
         r[i] = sda_in; // Stable while clock high
      end
      q = r[8:1];
      ack = r[0];
   endtask
endmodule

`default_nettype wire

// *** sim/testbench.sv ***
// Testbench for the four-channel switch control logic.
// Assumes rtl, host model and checker are compiled first.
`include "isw_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import isw_pkg::*;
   logic         mclk;
   logic         rst_b;
   logic [3:0]   irq_in;
   logic [1:0]   strap;
   logic [3:0]   ds_hold;
   logic         irq_n;
   logic [3:0]   ck_oe;
   logic [3:0]   dt_oe;
   logic [3:0]   enab;
   isw_line_type line_in;
   isw_line_type line_oe;
   wire logic    scl_h;
   wire logic    sda_h;
   int           fail_count = 0;
   int           check_count = 0;
   int           cyc = 0;
   // ==========
   // Wired-AND lines with pull-ups; ds_hold is a downstream device holding its clock
   assign line_in = {scl_h & ~line_oe.scl, sda_h & ~line_oe.sda};
   isw_host isw_host_inst (.mclk, .sda_in(line_in.sda), .scl_drv(scl_h), .sda_drv(sda_h));
   isw_switch isw_switch_inst (
      .mclk, .rst_b, .up_line_in(line_in), .up_line_out(), .up_line_oe(line_oe),
      .downstream_clock_in(~ck_oe & ~ds_hold),
      .downstream_clock_out(), .downstream_clock_oe(ck_oe),
      .downstream_data_in(~dt_oe), .downstream_data_out(), .downstream_data_oe(dt_oe),
      .channel_irq_n(irq_in), .irq_n, .addr_sel_lo(strap[0]), .addr_sel_hi(strap[1]),
      .chan_enable(enab));
   // Clock and hang guard
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   // ==========
   // Shared tasks
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic logic [7:0] adr(input logic [1:0] s, input logic rw);
      return {`ISW_ADDR_BASE, s, rw};
   endfunction
   // Selection applies at bus idle, so allow a few cycles after stop
   task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic ak);
      logic [7:0] q;
      logic       k;
      isw_host_inst.start_cond();
      isw_host_inst.xfer_byte(a, 1'b1, q, ak);
      if (ak === 1'b0)
         isw_host_inst.xfer_byte(v, 1'b1, q, k);
      isw_host_inst.stop_cond();
      repeat (4) @(posedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic ak);
      logic k;
      isw_host_inst.start_cond();
      isw_host_inst.xfer_byte(a, 1'b1, q, ak);
      isw_host_inst.xfer_byte(8'hff, 1'b1, q, k);
      isw_host_inst.stop_cond();
   endtask
   // ==========
   // Scenarios
   task automatic t_irq;
      for (int i = 0; i < 16; i++) begin
         irq_in <= 4'(i);
         repeat (2) @(posedge mclk);
         check("irq_n", 8'(irq_n), 8'(i == 15));
      end
      irq_in <= 4'hf;
      $display("test irq done");
   endtask
   // Every selection, with the straps walked through all four values
   task automatic t_select;
      logic       ak;
      logic [7:0] q;
      for (int v = 0; v < 16; v++) begin
         strap <= 2'(v);
         @(posedge mclk);
         wr(adr(2'(v), 1'b0), {4'ha, 4'(v)}, ak);
         check("write ack", 8'(ak), 8'h00);
         check("chan_enable", 8'(enab), 8'(v));
         rd(adr(2'(v), 1'b1), q, ak);
         check("read back", q, 8'(v));
      end
      wr(adr(2'h1, 1'b0), 8'h03, ak);
      check("foreign ack", 8'(ak), 8'h01);
      check("chan_enable", 8'(enab), 8'h0f);
      $display("test select done");
   endtask
   // 32 bytes fill the buffer; the 33rd is refused
   task automatic t_fifo;
      logic       ak;
      logic [7:0] q;
      isw_host_inst.start_cond();
      isw_host_inst.xfer_byte(adr(strap, 1'b0), 1'b1, q, ak);
      for (int i = 0; i < 33; i++) begin
         isw_host_inst.xfer_byte(8'(i + 3), 1'b1, q, ak);
         check("fifo ack", 8'(ak), 8'(i == 32));
      end
      isw_host_inst.stop_cond();
      // 32 queued bytes drain one per cycle once the bus is idle
      repeat (40) @(posedge mclk);
      check("last wins", 8'(enab), 8'h02);
      $display("test fifo done");
   endtask
   task automatic t_midreset;
      logic       ak;
      logic [7:0] q;
      isw_host_inst.start_cond();
      isw_host_inst.xfer_byte(adr(strap, 1'b0), 1'b1, q, ak);
      rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      check("chan_enable", 8'(enab), 8'h00);
      check("up_line_oe", 8'(line_oe), 8'h00);
      rst_b <= 1'b1;
      isw_host_inst.stop_cond();
      wr(adr(strap, 1'b0), 8'h09, ak);
      check("chan_enable", 8'(enab), 8'h09);
      isw_host_inst.half = 60;
      wr(adr(strap, 1'b0), 8'h06, ak);
      rd(adr(strap, 1'b1), q, ak);
      check("slow read", q, 8'h06);
      isw_host_inst.half = 25;
      $display("test reset and slow clock done");
   endtask
   // Downstream clock held low: relayed upstream only on enabled channels (1 and 2)
   task automatic t_relay;
      ds_hold <= 4'h1;
      repeat (4) @(posedge mclk);
      check("off channel relay", 8'(line_oe), 8'h00);
      ds_hold <= 4'h2;
      repeat (4) @(posedge mclk);
      check("clock relay", 8'(line_oe), 8'h02);
      ds_hold <= 4'h0;
      repeat (4) @(posedge mclk);
      check("relay release", 8'(line_oe), 8'h00);
      $display("test relay done");
   endtask
   // ==========
   // Main sequence
   initial begin
      rst_b = 1'b0;
      irq_in = 4'hf;
      strap = 2'h0;
      ds_hold = 4'h0;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      check("chan_enable", 8'(enab), 8'h00);
      check("irq_n", 8'(irq_n), 8'h01);
      check("up_line_oe", 8'(line_oe), 8'h00);
      t_irq();
      t_select();
      t_fifo();
      t_midreset();
      t_relay();
      tally_and_finish();
   end
endmodule

`default_nettype wire
